// file: core/tai_temp_alarm.sv
// temperature alarm, thermal trip and serial register slave of the monitor
// assumes converter results arrive on clk_sys_in; bus pins are asynchronous
// Function
// - alarm pin pulled low on out-of-limit reading or open remote diode
// - alarm when temperature above high limit or at/below low limit
// - in alarm mode, asserting device acks alert response read, returns address with lsb 1
// - after alert response, alarm released only if cause has gone
// - alarm release needs below-high, address read and status cleared
// - lowest address wins alert response by arbitration; losers stay asserted
// - config bit 6 enters standby, aborts conversion without storing result
// - serial bus keeps working in standby
// - one-shot write converts both channels once, data ignored
// - limits writable in standby; new limits can raise the alarm
// - open detector sampled at conversion start, sets status bit 2
// - in alarm mode, open flag pulls alarm pin low
// - alarm pin maskable, thermal trip never masked
// - thermal trip low when local or remote above its trip limit
// - trip releases at limit minus hysteresis, shared by both channels
// - both trip limits reset to 85 degrees
// - hysteresis resets to 10 degrees and stays writable
// - hysteresis is plain binary, one degree per lsb
// - secondary trip mode: pin low above high limits, unmaskable
// - secondary trip releases at high limit minus hysteresis
`timescale 1ns/1ps
`include "tai_regs.svh"

module tai_temp_alarm #(
  parameter int unsigned CONV_CYCLES = `TAI_CONV_CYCLES,
  parameter logic [6:0] DEV_ADDR = `TAI_DEV_ADDR
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic smb_scl_in,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe_out,
  output logic alarm_n_out,
  output logic alarm_oe_out,
  output logic thermal_trip_n_out,
  output logic thermal_trip_oe_out,
  input wire logic diode_open_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  input wire logic conv_done_in,
  input wire tai_pkg::tai_result_t conv_result_in
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers and bus edge detection
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q, open_m_q, open_s_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {open_m_q, open_s_q} <= 2'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {smb_scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {smb_sda_in, sda_m_q, sda_s_q};
      {open_m_q, open_s_q} <= {diode_open_in, open_m_q};
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] config_q, loc_high_q, loc_low_q, rem_high_q, rem_low_q;
  logic [7:0] loc_trip_lim_q, rem_trip_lim_q, hyst_q, status_q, ptr_q;
  tai_pkg::tai_result_t value_q;
  logic valid_q, wr_en, rd_status, ara_served;
  logic [7:0] wr_data, rd_data;
  logic standby, trip2_mode, masked;
  assign standby = config_q[`TAI_CFG_STANDBY];
  assign trip2_mode = config_q[`TAI_CFG_TRIP2];
  assign masked = config_q[`TAI_CFG_MASK];

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_q <= `TAI_RST_CONFIG;
      loc_high_q <= `TAI_RST_HIGH;
      rem_high_q <= `TAI_RST_HIGH;
      loc_low_q <= `TAI_RST_LOW;
      rem_low_q <= `TAI_RST_LOW;
      loc_trip_lim_q <= `TAI_RST_TRIP_LIM;
      rem_trip_lim_q <= `TAI_RST_TRIP_LIM;
      hyst_q <= `TAI_RST_HYST;
    end else if (wr_en) begin
      // limits stay writable in standby
      if (ptr_q == `TAI_WR_CONFIG) begin
        config_q <= wr_data;
      end else if (ptr_q == `TAI_WR_LOC_HIGH) begin
        loc_high_q <= wr_data;
      end else if (ptr_q == `TAI_WR_LOC_LOW) begin
        loc_low_q <= wr_data;
      end else if (ptr_q == `TAI_WR_REM_HIGH) begin
        rem_high_q <= wr_data;
      end else if (ptr_q == `TAI_WR_REM_LOW) begin
        rem_low_q <= wr_data;
      end else if (ptr_q == `TAI_REM_TRIP_LIM) begin
        rem_trip_lim_q <= wr_data;
      end else if (ptr_q == `TAI_LOC_TRIP_LIM) begin
        loc_trip_lim_q <= wr_data;
      end else if (ptr_q == `TAI_TRIP_HYST) begin
        hyst_q <= wr_data;
      end
    end
  end

  always_comb begin
    if (ptr_q == `TAI_RD_LOCAL_TEMP) begin
      rd_data = value_q.local_temp;
    end else if (ptr_q == `TAI_RD_REMOTE_TEMP) begin
      rd_data = value_q.remote_temp;
    end else if (ptr_q == `TAI_RD_STATUS) begin
      rd_data = status_q;
    end else if (ptr_q == `TAI_RD_CONFIG || ptr_q == `TAI_WR_CONFIG) begin
      rd_data = config_q;
    end else if (ptr_q == `TAI_RD_LOC_HIGH) begin
      rd_data = loc_high_q;
    end else if (ptr_q == `TAI_RD_LOC_LOW) begin
      rd_data = loc_low_q;
    end else if (ptr_q == `TAI_RD_REM_HIGH) begin
      rd_data = rem_high_q;
    end else if (ptr_q == `TAI_RD_REM_LOW) begin
      rd_data = rem_low_q;
    end else if (ptr_q == `TAI_REM_TRIP_LIM) begin
      rd_data = rem_trip_lim_q;
    end else if (ptr_q == `TAI_LOC_TRIP_LIM) begin
      rd_data = loc_trip_lim_q;
    end else if (ptr_q == `TAI_TRIP_HYST) begin
      rd_data = hyst_q;
    end else begin
      rd_data = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion scheduling
  logic [CW-1:0] timer_q;
  logic busy_q, oneshot_pend_q, oneshot_run_q, tick, start, abort;
  assign tick = (timer_q == CW'(CONV_CYCLES - 1));
  assign start = ~busy_q & ((tick & ~standby) | oneshot_pend_q);
  assign abort = busy_q & standby & ~oneshot_run_q;
  assign conv_start_out = start;
  assign conv_abort_out = abort;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_q <= '0;
      busy_q <= 1'b0;
      oneshot_pend_q <= 1'b0;
      oneshot_run_q <= 1'b0;
    end else begin
      timer_q <= tick ? '0 : timer_q + CW'(1);
      if (start) begin
        busy_q <= 1'b1;
        oneshot_run_q <= oneshot_pend_q;
      end else if (abort || conv_done_in) begin
        busy_q <= 1'b0;
        oneshot_run_q <= 1'b0;
      end
      if (wr_en && ptr_q == `TAI_ONE_SHOT) begin
        oneshot_pend_q <= 1'b1;
      end else if (start) begin
        oneshot_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_q <= '0;
      valid_q <= 1'b0;
    end else if (conv_done_in && busy_q && !abort) begin
      value_q <= conv_result_in;
      valid_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // limit checks, trip comparators with hysteresis
  function automatic logic trip_next(input logic cur, input logic [7:0] t,
                                     input logic [7:0] lim, input logic [7:0] hy);
    logic [8:0] sum;
    sum = {1'b0, t} + {1'b0, hy};
    trip_next = (t > lim) || (cur && (sum > {1'b0, lim}));
  endfunction

  logic loc_trip_q, rem_trip_q, loc_t2_q, rem_t2_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {loc_trip_q, rem_trip_q, loc_t2_q, rem_t2_q} <= 4'h0;
    end else if (valid_q) begin
      loc_trip_q <= trip_next(loc_trip_q, value_q.local_temp, loc_trip_lim_q, hyst_q);
      rem_trip_q <= trip_next(rem_trip_q, value_q.remote_temp, rem_trip_lim_q, hyst_q);
      loc_t2_q <= trip_next(loc_t2_q, value_q.local_temp, loc_high_q, hyst_q);
      rem_t2_q <= trip_next(rem_t2_q, value_q.remote_temp, rem_high_q, hyst_q);
    end
  end

  logic [7:0] status_set;
  always_comb begin
    status_set = 8'h00;
    status_set[`TAI_ST_LOC_HIGH] = valid_q && (value_q.local_temp > loc_high_q);
    status_set[`TAI_ST_LOC_LOW] = valid_q && (value_q.local_temp <= loc_low_q);
    status_set[`TAI_ST_REM_HIGH] = valid_q && (value_q.remote_temp > rem_high_q);
    status_set[`TAI_ST_REM_LOW] = valid_q && (value_q.remote_temp <= rem_low_q);
    status_set[`TAI_ST_OPEN] = start && open_s_q;
    status_set[`TAI_ST_REM_TRIP] = rem_trip_q;
    status_set[`TAI_ST_LOC_TRIP] = loc_trip_q;
  end

  // read clears, a live condition sets it again in the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= 8'h00;
    end else begin
      status_q <= (rd_status ? 8'h00 : status_q) | status_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // alarm pin
  logic alert_q, served_q, alert_src;
  assign alert_src = |status_q[`TAI_ST_LOC_HIGH:`TAI_ST_OPEN];
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_q <= 1'b0;
      served_q <= 1'b0;
    end else begin
      if (alert_src && !masked) begin
        alert_q <= 1'b1;
      end else if (served_q && !(|status_set[`TAI_ST_LOC_HIGH:`TAI_ST_OPEN])) begin
        alert_q <= 1'b0;
      end
      if (ara_served) begin
        served_q <= 1'b1;
      end else if (!alert_q) begin
        served_q <= 1'b0;
      end
    end
  end

  logic pin_low_q, trip_low_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_low_q <= 1'b0;
      trip_low_q <= 1'b0;
    end else begin
      pin_low_q <= trip2_mode ? (loc_t2_q | rem_t2_q) : alert_q;
      trip_low_q <= loc_trip_q | rem_trip_q;
    end
  end
  assign alarm_n_out = 1'b0;
  assign alarm_oe_out = pin_low_q;
  assign thermal_trip_n_out = 1'b0;
  assign thermal_trip_oe_out = trip_low_q;

  //////////////////////////////////////////////////////////////////////////////
  // serial bus slave, runs in standby too
  tai_pkg::tai_smb_state_t st_q;
  logic [2:0] bit_q;
  logic [1:0] byte_idx_q;
  logic [7:0] shift_q, tx_q;
  logic done_q, read_q, ara_q, drive_q;
  logic [7:0] rx_byte;
  assign rx_byte = shift_q;
  assign wr_en = (st_q == tai_pkg::TAI_WBYTE) && scl_fall && done_q && (byte_idx_q == 2'd1);
  assign wr_data = rx_byte;
  assign rd_status = (st_q == tai_pkg::TAI_ADDR_ACK) && scl_fall && read_q && !ara_q &&
                     (ptr_q == `TAI_RD_STATUS);
  assign ara_served = (st_q == tai_pkg::TAI_RACK) && scl_rise && ara_q;
  assign smb_sda_out = 1'b0;
  assign smb_sda_oe_out = drive_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= tai_pkg::TAI_IDLE;
      bit_q <= 3'h0;
      byte_idx_q <= 2'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      done_q <= 1'b0;
      read_q <= 1'b0;
      ara_q <= 1'b0;
      drive_q <= 1'b0;
      ptr_q <= 8'h00;
    end else if (bus_start) begin
      st_q <= tai_pkg::TAI_ADDR;
      bit_q <= 3'h0;
      byte_idx_q <= 2'h0;
      done_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (bus_stop) begin
      st_q <= tai_pkg::TAI_IDLE;
      drive_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_q <= {shift_q[6:0], sda_s_q};
        bit_q <= bit_q + 3'h1;
        done_q <= (bit_q == 3'h7);
      end
      case (st_q)
        tai_pkg::TAI_ADDR: begin
          if (scl_fall && done_q) begin
            done_q <= 1'b0;
            read_q <= shift_q[0];
            if (shift_q[7:1] == DEV_ADDR) begin
              ara_q <= 1'b0;
              drive_q <= 1'b1;
              st_q <= tai_pkg::TAI_ADDR_ACK;
            end else if (shift_q == {`TAI_ARA_ADDR, 1'b1} && alert_q && !trip2_mode) begin
              ara_q <= 1'b1;
              drive_q <= 1'b1;
              st_q <= tai_pkg::TAI_ADDR_ACK;
            end else begin
              st_q <= tai_pkg::TAI_IDLE;
            end
          end
        end
        tai_pkg::TAI_ADDR_ACK, tai_pkg::TAI_RACK: begin
          if (scl_fall) begin
            // ack clock is not a data bit, next byte counts from zero
            bit_q <= 3'h0;
            if (st_q == tai_pkg::TAI_ADDR_ACK && !read_q) begin
              drive_q <= 1'b0;
              st_q <= tai_pkg::TAI_WBYTE;
            end else if (st_q == tai_pkg::TAI_RACK && sda_p_q) begin
              drive_q <= 1'b0;
              st_q <= tai_pkg::TAI_IDLE;
            end else begin
              tx_q <= ara_q ? {DEV_ADDR, 1'b1} : rd_data;
              drive_q <= ara_q ? ~DEV_ADDR[6] : ~rd_data[7];
              st_q <= tai_pkg::TAI_RBYTE;
            end
          end
        end
        tai_pkg::TAI_RBYTE: begin
          if (scl_rise && !drive_q && !sda_s_q) begin
            st_q <= tai_pkg::TAI_IDLE;
          end else if (scl_fall && done_q) begin
            done_q <= 1'b0;
            drive_q <= 1'b0;
            st_q <= tai_pkg::TAI_RACK;
          end else if (scl_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
            drive_q <= ~tx_q[6];
          end
        end
        tai_pkg::TAI_WBYTE: begin
          if (scl_fall && done_q) begin
            done_q <= 1'b0;
            drive_q <= 1'b1;
            st_q <= tai_pkg::TAI_WACK;
            if (byte_idx_q == 2'd0) begin
              ptr_q <= rx_byte;
            end
            if (byte_idx_q != 2'd2) begin
              byte_idx_q <= byte_idx_q + 2'd1;
            end
          end
        end
        tai_pkg::TAI_WACK: begin
          if (scl_fall) begin
            bit_q <= 3'h0;
            drive_q <= 1'b0;
            st_q <= tai_pkg::TAI_WBYTE;
          end
        end
        default: begin
          drive_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: core/tai_regs.svh
// register offsets, field positions, reset values and timing of the alarm block
// assumes a 100 MHz system clock
`ifndef TAI_REGS_SVH
`define TAI_REGS_SVH
`define TAI_RD_LOCAL_TEMP 8'h00
`define TAI_RD_REMOTE_TEMP 8'h01
`define TAI_RD_STATUS 8'h02
`define TAI_RD_CONFIG 8'h03
`define TAI_RD_LOC_HIGH 8'h05
`define TAI_RD_LOC_LOW 8'h06
`define TAI_RD_REM_HIGH 8'h07
`define TAI_RD_REM_LOW 8'h08
`define TAI_WR_CONFIG 8'h09
`define TAI_WR_LOC_HIGH 8'h0B
`define TAI_WR_LOC_LOW 8'h0C
`define TAI_WR_REM_HIGH 8'h0D
`define TAI_WR_REM_LOW 8'h0E
`define TAI_ONE_SHOT 8'h0F
`define TAI_REM_TRIP_LIM 8'h19
`define TAI_LOC_TRIP_LIM 8'h20
`define TAI_TRIP_HYST 8'h21
`define TAI_CFG_MASK 7
`define TAI_CFG_STANDBY 6
`define TAI_CFG_TRIP2 5
`define TAI_ST_LOC_HIGH 6
`define TAI_ST_LOC_LOW 5
`define TAI_ST_REM_HIGH 4
`define TAI_ST_REM_LOW 3
`define TAI_ST_OPEN 2
`define TAI_ST_REM_TRIP 1
`define TAI_ST_LOC_TRIP 0
`define TAI_RST_CONFIG 8'h00
`define TAI_RST_HIGH 8'h55
`define TAI_RST_LOW 8'h00
`define TAI_RST_TRIP_LIM 8'h55
`define TAI_RST_HYST 8'h0A
`define TAI_DEV_ADDR 7'h4C
`define TAI_ARA_ADDR 7'h0C
`define TAI_CLK_PERIOD_NS 10
`define TAI_CONV_PERIOD_NS 62500000
`define TAI_CONV_CYCLES (`TAI_CONV_PERIOD_NS / `TAI_CLK_PERIOD_NS)
`endif

// file: core/tai_pkg.sv
// types shared by the alarm block and its bench
// no dependencies
package tai_pkg;
  typedef enum logic [2:0] {
    TAI_IDLE, TAI_ADDR, TAI_ADDR_ACK, TAI_WBYTE, TAI_WACK, TAI_RBYTE, TAI_RACK
  } tai_smb_state_t;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
  } tai_result_t;
endpackage

// file: bench/tai_temp_alarm_checker.sv
// concurrent checks on the ports of the alarm block
// assumes scl low phases of at least five system clocks
`timescale 1ns/1ps
module tai_temp_alarm_checker (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic smb_scl_in,
  input wire logic smb_sda_oe_out,
  input wire logic alarm_oe_out,
  input wire logic thermal_trip_oe_out,
  input wire logic conv_start_out,
  input wire logic conv_abort_out,
  input wire logic conv_done_in,
  input wire tai_pkg::tai_result_t conv_result_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic seen_q, busy_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seen_q <= 1'b0;
    end else if (conv_start_out) begin
      seen_q <= 1'b1;
    end
  end
  // conversion in flight as seen on the converter handshake
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_q <= 1'b0;
    end else if (conv_start_out) begin
      busy_q <= 1'b1;
    end else if (conv_abort_out || conv_done_in) begin
      busy_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_hot;
    conv_done_in && conv_result_in.remote_temp == 8'hFF;
  endsequence
  sequence s_cold;
    conv_done_in && conv_result_in == 16'h0000;
  endsequence
  a_reset_quiet: assert property (
    $rose(reset_n_in) |-> !alarm_oe_out && !thermal_trip_oe_out && !smb_sda_oe_out)
    else $error("output active after reset");
  a_quiet_before_conv: assert property (
    !seen_q |-> !alarm_oe_out && !thermal_trip_oe_out)
    else $error("alarm without any conversion");
  a_start_spacing: assert property (conv_start_out |=> !conv_start_out [*6])
    else $error("conversion restarted while busy");
  a_start_abort: assert property (conv_abort_out |-> busy_q && !conv_start_out)
    else $error("abort without a conversion in flight");
  a_trip_hot: assert property (s_hot |-> ##[1:3] thermal_trip_oe_out)
    else $error("trip not raised");
  a_trip_cold: assert property (s_cold |-> ##[1:3] !thermal_trip_oe_out)
    else $error("trip not released");
  a_sda_change_low: assert property (
    $changed(smb_sda_oe_out) |-> !$past(smb_scl_in))
    else $error("sda changed while scl high");
  a_idle_release: assert property (smb_scl_in [*6] |-> !smb_sda_oe_out)
    else $error("sda held while bus idle");
endmodule
bind tai_temp_alarm tai_temp_alarm_checker u_chk (.clk_sys_in, .reset_n_in, .smb_scl_in,
  .smb_sda_oe_out, .alarm_oe_out, .thermal_trip_oe_out, .conv_start_out, .conv_abort_out,
  .conv_done_in, .conv_result_in);

// file: bench/tai_smb_host.sv
// serial bus host model: drives scl, pulls sda, reads the shared line
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module tai_smb_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start();
    tick(3);
    sda_pull_out = 1'b1;
    tick(3);
    scl_out = 1'b0;
  endtask
  // five clocks low, three high: 80 ns a bit
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sda_pull_out = !b;
    tick(4);
    scl_out = 1'b1;
    tick(3);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_pull_out = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(3);
    sda_pull_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(1'b1, a);
    ack = !a;
  endtask
  // write frames need every byte acked, read frames end with a release
  task automatic frame(input logic [7:0] a, p, v, input int n, output logic [7:0] q,
                       output logic ok);
    logic k;
    start();
    xfer(a, q, ok);
    for (int i = 1; i < n; i++) begin
      xfer(i == 1 ? p : v, q, k);
      ok = ok & (k | a[0]);
    end
    stop();
  endtask
endmodule

// file: bench/tai_temp_alarm_tb_top.sv
// self-checking bench of the alarm block with host and converter models
// assumes the design package and register header are compiled first
`timescale 1ns/1ps
`include "tai_regs.svh"
module tai_temp_alarm_tb_top;
  localparam int CONV = 200;
  logic clk_sys_in = 1'b0;
  logic reset_n_in, diode_open_in, host_pull, scl, ok;
  logic conv_done_in = 1'b0;
  logic smb_sda_oe_out, alarm_oe_out, thermal_trip_oe_out, conv_start_out, conv_abort_out;
  tai_pkg::tai_result_t res;
  logic [7:0] d, hy, c;
  wire sda_w;
  int n_fail, n_checks, cv_cnt;
  int n_start = 0;
  int n_done = 0;
  int n_abort = 0;
  assign sda_w = !(host_pull | smb_sda_oe_out);
  always #5 clk_sys_in = !clk_sys_in;
  tai_temp_alarm #(.CONV_CYCLES(CONV)) dut (
    .clk_sys_in, .reset_n_in, .smb_scl_in(scl), .smb_sda_in(sda_w), .smb_sda_out(),
    .smb_sda_oe_out, .alarm_n_out(), .alarm_oe_out, .thermal_trip_n_out(),
    .thermal_trip_oe_out, .diode_open_in, .conv_start_out, .conv_abort_out,
    .conv_done_in, .conv_result_in(res));
  tai_smb_host host (.clk_in(clk_sys_in), .sda_in(sda_w), .scl_out(scl),
    .sda_pull_out(host_pull));
  ////////////////////////////////////////////////////////////////
  // converter: answers eight clocks after a start
  always @(negedge clk_sys_in) begin
    conv_done_in <= cv_cnt == 1 && !conv_abort_out;
    if (!reset_n_in || conv_abort_out) cv_cnt <= 0;
    else if (conv_start_out) cv_cnt <= 8;
    else if (cv_cnt != 0) cv_cnt <= cv_cnt - 1;
  end
  always @(posedge clk_sys_in) begin
    n_start <= n_start + int'(conv_start_out);
    n_done <= n_done + int'(conv_done_in && !conv_abort_out);
    n_abort <= n_abort + int'(conv_abort_out);
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) fail("flag differs");
  endtask
  task automatic wrc(input logic [7:0] p, input logic [7:0] v);
    host.frame({`TAI_DEV_ADDR, 1'b0}, p, v, 3, d, ok);
    chk1(ok, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] p);
    host.frame({`TAI_DEV_ADDR, 1'b0}, p, 8'h00, 2, d, ok);
    host.frame({`TAI_DEV_ADDR, 1'b1}, 8'hFF, 8'hFF, 2, d, ok);
  endtask
  task automatic ara();
    host.frame({`TAI_ARA_ADDR, 1'b1}, 8'hFF, 8'hFF, 2, d, ok);
  endtask
  task automatic clear_alarm();
    rdc(8'h02);
    for (int i = 0; i < 3 && alarm_oe_out; i++) ara();
  endtask
  task automatic measure(input logic [15:0] v);
    int k;
    res = v;
    k = n_done;
    for (int i = 0; i < 3 * CONV && n_done == k; i++) @(negedge clk_sys_in);
    if (n_done == k) begin
      fail("no conversion");
      final_report();
    end
    repeat (4) @(negedge clk_sys_in);
  endtask
  function automatic logic [15:0] pick(input int ch, input logic [7:0] t);
    return ch != 0 ? {c, t} : {t, c};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    int k;
    n_fail = 0;
    n_checks = 0;
    reset_n_in = 1'b0;
    diode_open_in = 1'b0;
    res = '0;
    void'($urandom(29));
    hy = 8'($urandom_range(12, 1));
    c = 8'($urandom_range(8'h40, 8'h01));
    repeat (3) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    rdc(8'h20);
    chk8(d, 8'h55);
    rdc(8'h19);
    chk8(d, 8'h55);
    rdc(8'h21);
    chk8(d, 8'h0A);
    wrc(8'h21, hy);
    rdc(8'h21);
    chk8(d, hy);
    for (int ch = 0; ch < 2; ch++) begin
      measure(pick(ch, 8'h56));
      chk1(thermal_trip_oe_out, 1'b1);
      chk1(alarm_oe_out, 1'b1);
      measure(pick(ch, 8'h56 - hy));
      chk1(thermal_trip_oe_out, 1'b1);
      measure(pick(ch, 8'h55 - hy));
      chk1(thermal_trip_oe_out, 1'b0);
    end
    measure({8'h56, c});
    ara();
    chk8(d, {`TAI_DEV_ADDR, 1'b1});
    chk1(alarm_oe_out, 1'b1);
    measure({c, c});
    ara();
    chk1(alarm_oe_out, 1'b1);
    clear_alarm();
    chk1(alarm_oe_out, 1'b0);
    measure(16'h0000);
    chk1(alarm_oe_out, 1'b1);
    measure({c, c});
    clear_alarm();
    wrc(8'h09, 8'h80);
    measure(16'h60FF);
    chk1(alarm_oe_out, 1'b0);
    chk1(thermal_trip_oe_out, 1'b1);
    measure({c, c});
    rdc(8'h02);
    wrc(8'h09, 8'hA0);
    measure({8'h56, c});
    chk1(alarm_oe_out, 1'b1);
    wrc(8'h09, 8'h20);
    ara();
    chk1(ok, 1'b0);
    measure({8'h56 - hy, c});
    chk1(alarm_oe_out, 1'b1);
    measure({8'h55 - hy, c});
    chk1(alarm_oe_out, 1'b0);
    wrc(8'h09, 8'h40);
    clear_alarm();
    chk1(alarm_oe_out, 1'b0);
    k = n_start;
    repeat (3 * CONV) @(negedge clk_sys_in);
    chk8(8'(n_start - k), 8'h00);
    chk8(8'(n_start - n_done - n_abort), 8'h00);
    res = {8'h30, 8'h28};
    wrc(8'h0F, 8'($urandom()));
    repeat (3 * CONV) @(negedge clk_sys_in);
    chk8(8'(n_start - k), 8'h01);
    rdc(8'h00);
    chk8(d, 8'h30);
    wrc(8'h0B, 8'h2F);
    chk1(alarm_oe_out, 1'b1);
    wrc(8'h0B, 8'h55);
    clear_alarm();
    chk1(alarm_oe_out, 1'b0);
    diode_open_in = 1'b1;
    wrc(8'h0F, 8'h00);
    repeat (20) @(negedge clk_sys_in);
    diode_open_in = 1'b0;
    chk1(alarm_oe_out, 1'b1);
    rdc(8'h02);
    chk1(d[2], 1'b1);
    final_report();
  end
endmodule
